// ### design/rsatp_pkg.sv
package rsatp_pkg;

  // parameter identifiers of the output block
  localparam logic [7:0] OUT_ID_STATE_COMMAND  = 8'h0f;
  localparam logic [7:0] OUT_ID_REQUESTED      = 8'h13;
  localparam logic [7:0] OUT_ID_STATUS         = 8'h14;

  // parameter identifiers of the trip point block
  localparam logic [7:0] TRIP_ID_LOW_POINT     = 8'h13;
  localparam logic [7:0] TRIP_ID_LOW_ENABLE    = 8'h14;
  localparam logic [7:0] TRIP_ID_STATUS        = 8'h15;
  localparam logic [7:0] TRIP_ID_HYSTERESIS    = 8'h18;
  localparam logic [7:0] TRIP_ID_SOURCE        = 8'h1b;
  localparam logic [7:0] TRIP_ID_ATM_FRACTION  = 8'hc9;
  localparam logic [7:0] TRIP_ID_HIGH_POINT    = 8'hca;
  localparam logic [7:0] TRIP_ID_HIGH_ENABLE   = 8'hcb;

  // block select on the parameter port
  localparam logic       BLOCK_OUTPUT          = 1'b0;
  localparam logic       BLOCK_TRIP            = 1'b1;

  // state command codes
  localparam logic [7:0] CMD_AVAILABLE         = 8'h01;
  localparam logic [7:0] CMD_IDLE              = 8'h02;
  localparam logic [7:0] CMD_READY             = 8'h03;
  localparam logic [7:0] CMD_RUN               = 8'h04;
  localparam logic [7:0] CMD_RECOV_FAULT       = 8'h05;
  localparam logic [7:0] CMD_UNRECOV_FAULT     = 8'h06;

  // relay energise code and idle behaviour code for "force off"
  localparam logic [7:0] RELAY_ON_CODE         = 8'h01;
  localparam logic [7:0] IDLE_FORCE_OFF        = 8'h00;

  // sensor instance numbers and percentage scale
  localparam logic [7:0] DIAPHRAGM_INSTANCE    = 8'h01;
  localparam logic [7:0] AMBIENT_INSTANCE      = 8'h02;
  localparam int         PERCENT_SCALE         = 100;

  // reset values
  localparam logic [7:0]  RST_COMMAND          = 8'h00;
  localparam logic [7:0]  RST_REQUESTED        = 8'h00;
  localparam logic [15:0] RST_LOW_POINT        = 16'h0000;
  localparam logic [15:0] RST_HYSTERESIS       = 16'h0000;
  localparam logic [7:0]  RST_ATM_FRACTION     = 8'h00;
  localparam logic [15:0] RST_HIGH_POINT       = 16'h0000;

  typedef enum logic [2:0] {
    ST_AVAILABLE,
    ST_IDLE,
    ST_READY,
    ST_RUN,
    ST_RECOV_FAULT,
    ST_UNRECOV_FAULT
  } rsatp_state_type;

  // one parameter access from the fieldbus side
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        block;
    logic [7:0]  id;
    logic [15:0] wdata;
  } rsatp_param_type;

  // one measured value from a sensor instance
  typedef struct packed {
    logic               valid;
    logic signed [15:0] value;
  } rsatp_sample_type;

endpackage : rsatp_pkg

// ### design/rsatp_relay_trip.sv
`timescale 1ns/1ps
module rsatp_relay_trip
  import rsatp_pkg::*;
(
  input  wire logic             i_mclk,
  input  wire logic             i_resetn,
  input  wire rsatp_param_type  i_param,
  input  wire logic             i_device_executing,
  input  wire logic [7:0]       i_idle_behaviour_selector,
  input  wire logic             i_recoverable_fault,
  input  wire logic             i_unrecoverable_fault,
  input  wire logic             i_fault_is_critical,
  input  wire rsatp_sample_type i_diaphragm_sensor,
  input  wire rsatp_sample_type i_ambient_sensor,
  output logic [15:0]           o_param_rdata,
  output logic [2:0]            o_output_state,
  output logic                  o_relay,
  output logic                  o_trip_status,
  output logic                  o_critical_fault
);

  // decode of a parameter access aimed at one block and identifier
  function automatic logic hit(input rsatp_param_type p, input logic blk,
                               input logic [7:0] id);
    hit = (p.block == blk) && (p.id == id);
  endfunction : hit

  // output block state, command copy and relay path
  rsatp_state_type    state;
  rsatp_state_type    next_state;
  logic [7:0]         command;
  logic [7:0]         next_command;
  logic [7:0]         requested_output_value;
  logic [7:0]         next_requested_output_value;
  logic               next_relay;
  logic               next_critical_fault;
  // trip point parameters and status
  logic signed [15:0] low_point;
  logic signed [15:0] next_low_point;
  logic signed [15:0] hysteresis;
  logic signed [15:0] next_hysteresis;
  logic               low_enable;
  logic               next_low_enable;
  logic [7:0]         atmosphere_fraction;
  logic [7:0]         next_atmosphere_fraction;
  logic signed [15:0] high_point;
  logic signed [15:0] next_high_point;
  logic               next_trip_status;
  // read port
  logic [15:0]        next_param_rdata;
  // widened threshold arithmetic
  logic signed [31:0] product;
  logic signed [17:0] low_release;
  logic signed [17:0] high_release;

  // output block state machine, requested value and relay drive
  always_comb
  begin
    next_state                  = state;
    next_command                = command;
    next_requested_output_value = requested_output_value;
    next_relay                  = o_relay;
    next_critical_fault         = o_critical_fault;
    // requested value is stored even while frozen; the state machine, command copy and critical fault are gated
    if (i_param.wr && hit(i_param, BLOCK_OUTPUT, OUT_ID_REQUESTED))
    begin
      next_requested_output_value = i_param.wdata[7:0];
    end
    // the machine moves only while the device block executes
    if (i_device_executing)
    begin
      // every write is an event; unknown codes are kept for read back only
      if (i_param.wr && hit(i_param, BLOCK_OUTPUT, OUT_ID_STATE_COMMAND))
      begin
        next_command = i_param.wdata[7:0];
        case (i_param.wdata[7:0])
          CMD_AVAILABLE:     next_state = ST_AVAILABLE;
          CMD_IDLE:          next_state = ST_IDLE;
          CMD_READY:         next_state = ST_READY;
          CMD_RUN:           next_state = ST_RUN;
          CMD_RECOV_FAULT:   next_state = ST_RECOV_FAULT;
          CMD_UNRECOV_FAULT: next_state = ST_UNRECOV_FAULT;
          default:           next_state = state;
        endcase
      end
      // fault inputs win over a same-cycle command write, except a recoverable fault in ST_UNRECOV_FAULT
      if (i_recoverable_fault && state != ST_UNRECOV_FAULT)
      begin
        next_state = ST_RECOV_FAULT;
      end
      // no automatic exit from here; only a command write leaves it
      if (i_unrecoverable_fault)
      begin
        next_state          = ST_UNRECOV_FAULT;
        next_critical_fault = o_critical_fault | i_fault_is_critical;
      end
    end
    // relay follows the requested value only while the path is connected
    case (state)
      ST_READY, ST_RUN:
        next_relay = (requested_output_value == RELAY_ON_CODE);
      // a nonzero selector leaves the relay where it was
      ST_IDLE:
        if (i_idle_behaviour_selector == IDLE_FORCE_OFF)
        begin
          next_relay = 1'b0;
        end
      default:
        next_relay = 1'b0;
    endcase
  end

  // state machine and relay registers
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state                  <= ST_AVAILABLE;
      command                <= RST_COMMAND;
      requested_output_value <= RST_REQUESTED;
      o_relay                <= 1'b0;
      o_critical_fault       <= 1'b0;
    end
    else
    begin
      state                  <= next_state;
      command                <= next_command;
      requested_output_value <= next_requested_output_value;
      o_relay                <= next_relay;
      o_critical_fault       <= next_critical_fault;
    end
  end

  // threshold arithmetic, widened so sums cannot wrap
  // both factors widened before the multiply so the product never wraps
  assign product      = 32'(signed'({1'b0, atmosphere_fraction})) * 32'(i_ambient_sensor.value);
  assign low_release  = 18'(low_point) + 18'(hysteresis);
  assign high_release = 18'(high_point) - 18'(hysteresis);

  // trip point parameters, threshold update and hysteresis comparator
  always_comb
  begin
    next_low_point           = low_point;
    next_hysteresis          = hysteresis;
    next_low_enable          = low_enable;
    next_atmosphere_fraction = atmosphere_fraction;
    next_high_point          = high_point;
    next_trip_status         = o_trip_status;
    // parameter writes from the master
    if (i_param.wr && hit(i_param, BLOCK_TRIP, TRIP_ID_LOW_POINT))
    begin
      next_low_point = i_param.wdata;
    end
    if (i_param.wr && hit(i_param, BLOCK_TRIP, TRIP_ID_HYSTERESIS))
    begin
      next_hysteresis = i_param.wdata;
    end
    // enabling the setpoint function switches detection off
    if (i_param.wr && hit(i_param, BLOCK_TRIP, TRIP_ID_LOW_ENABLE))
    begin
      next_low_enable = i_param.wdata[0];
      if (i_param.wdata[0])
      begin
        next_atmosphere_fraction = 8'h00;
      end
    end
    // a nonzero fraction switches the setpoint function off; it wins a tie
    if (i_param.wr && hit(i_param, BLOCK_TRIP, TRIP_ID_ATM_FRACTION))
    begin
      next_atmosphere_fraction = i_param.wdata[7:0];
      if (i_param.wdata[7:0] != 8'h00)
      begin
        next_low_enable = 1'b0;
      end
    end
    // threshold follows every ambient sample, whichever function is active
    if (i_ambient_sensor.valid)
    begin
      next_high_point = 16'(product / PERCENT_SCALE);
    end
    // comparator: the hysteresis band keeps the status from chattering
    if (atmosphere_fraction != 8'h00)
    begin
      // the newest ambient value meets the threshold of the previous sample
      if (i_ambient_sensor.valid)
      begin
        if (i_ambient_sensor.value >= high_point)
          next_trip_status = 1'b1;
        else if (18'(i_ambient_sensor.value) < high_release)
          next_trip_status = 1'b0;
      end
    end
    else if (low_enable)
    begin
      if (i_diaphragm_sensor.valid)
      begin
        if (i_diaphragm_sensor.value <= low_point)
          next_trip_status = 1'b1;
        else if (18'(i_diaphragm_sensor.value) > low_release)
          next_trip_status = 1'b0;
      end
    end
    else
    begin
      // with neither function enabled the status stays low
      next_trip_status = 1'b0;
    end
  end

  // trip point registers
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      low_point           <= RST_LOW_POINT;
      hysteresis          <= RST_HYSTERESIS;
      low_enable          <= 1'b0;
      atmosphere_fraction <= RST_ATM_FRACTION;
      high_point          <= RST_HIGH_POINT;
      o_trip_status       <= 1'b0;
    end
    else
    begin
      low_point           <= next_low_point;
      hysteresis          <= next_hysteresis;
      low_enable          <= next_low_enable;
      atmosphere_fraction <= next_atmosphere_fraction;
      high_point          <= next_high_point;
      o_trip_status       <= next_trip_status;
    end
  end

  // parameter read mux; unknown identifiers read zero
  always_comb
  begin
    next_param_rdata = 16'h0000;
    if (i_param.block == BLOCK_OUTPUT)
    begin
      case (i_param.id)
        OUT_ID_STATE_COMMAND: next_param_rdata = {8'h00, command};
        OUT_ID_REQUESTED:     next_param_rdata = {8'h00, requested_output_value};
        OUT_ID_STATUS:        next_param_rdata = {15'h0000, o_critical_fault};
        default:              next_param_rdata = 16'h0000;
      endcase
    end
    else
    begin
      case (i_param.id)
        TRIP_ID_LOW_POINT:    next_param_rdata = low_point;
        TRIP_ID_LOW_ENABLE:   next_param_rdata = {15'h0000, low_enable};
        TRIP_ID_STATUS:       next_param_rdata = {15'h0000, o_trip_status};
        TRIP_ID_HYSTERESIS:   next_param_rdata = hysteresis;
        TRIP_ID_SOURCE:       next_param_rdata = {8'h00, DIAPHRAGM_INSTANCE};
        TRIP_ID_ATM_FRACTION: next_param_rdata = {8'h00, atmosphere_fraction};
        TRIP_ID_HIGH_POINT:   next_param_rdata = high_point;
        // high enable is derived from the fraction, not stored
        TRIP_ID_HIGH_ENABLE:  next_param_rdata = {15'h0000, atmosphere_fraction != 8'h00};
        default:              next_param_rdata = 16'h0000;
      endcase
    end
    // without a read strobe the last answer keeps standing
    if (!i_param.rd)
    begin
      next_param_rdata = o_param_rdata;
    end
  end

  // read data and state copy registers
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_param_rdata  <= 16'h0000;
      o_output_state <= 3'(ST_AVAILABLE);
    end
    else
    begin
      o_param_rdata  <= next_param_rdata;
      o_output_state <= 3'(next_state);
    end
  end

endmodule : rsatp_relay_trip

// ### testbench/rsatp_relay_trip_sva.sv
`timescale 1ns/1ps
module rsatp_relay_trip_chk
  import rsatp_pkg::*;
(
  input wire logic             i_mclk,
  input wire logic             i_resetn,
  input wire rsatp_param_type  i_param,
  input wire logic             i_device_executing,
  input wire logic [7:0]       i_idle_behaviour_selector,
  input wire logic             i_recoverable_fault,
  input wire logic             i_unrecoverable_fault,
  input wire logic             i_fault_is_critical,
  input wire rsatp_sample_type i_diaphragm_sensor,
  input wire rsatp_sample_type i_ambient_sensor,
  input wire logic [15:0]      o_param_rdata,
  input wire logic [2:0]       o_output_state,
  input wire logic             o_relay,
  input wire logic             o_trip_status,
  input wire logic             o_critical_fault
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // accepted command write, any fault input, and no sample or write
  wire cmd_wr = i_param.wr && i_param.block == BLOCK_OUTPUT
                && i_param.id == OUT_ID_STATE_COMMAND && i_device_executing;
  wire flt    = i_recoverable_fault || i_unrecoverable_fault;
  wire quiet  = !i_diaphragm_sensor.valid && !i_ambient_sensor.valid && !i_param.wr;
  sequence s_cmd(logic [7:0] c);
    cmd_wr && !flt && i_param.wdata[7:0] == c;
  endsequence
  sequence s_crit;
    i_unrecoverable_fault && i_fault_is_critical && i_device_executing;
  endsequence
  property p_ready; s_cmd(CMD_READY) |=> o_output_state == ST_READY; endproperty
  a_ready: assert property (p_ready) else $error("ready command not taken");
  property p_idle;
    s_cmd(CMD_IDLE) ##1 (i_idle_behaviour_selector == IDLE_FORCE_OFF) |=> !o_relay;
  endproperty
  a_idle: assert property (p_idle) else $error("relay on in idle");
  property p_off;
    o_output_state inside {ST_AVAILABLE, ST_RECOV_FAULT, ST_UNRECOV_FAULT} |=> !o_relay;
  endproperty
  a_off: assert property (p_off) else $error("relay on outside ready or run");
  property p_frozen; !i_device_executing && !flt |=> $stable(o_output_state); endproperty
  a_frozen: assert property (p_frozen) else $error("state moved while frozen");
  property p_bad;
    cmd_wr && !flt && !(i_param.wdata[7:0] inside {[1:6]}) |=> $stable(o_output_state);
  endproperty
  a_bad: assert property (p_bad) else $error("reserved code moved state");
  property p_unrec_in;
    i_unrecoverable_fault && i_device_executing |=> o_output_state == ST_UNRECOV_FAULT;
  endproperty
  a_unrec_in: assert property (p_unrec_in) else $error("fault state not entered");
  property p_unrec_hold;
    o_output_state == ST_UNRECOV_FAULT && !cmd_wr |=> o_output_state == ST_UNRECOV_FAULT;
  endproperty
  a_unrec_hold: assert property (p_unrec_hold) else $error("fault state left");
  property p_crit; s_crit |=> o_critical_fault [*3]; endproperty
  a_crit: assert property (p_crit) else $error("critical fault not held");
  property p_trip_rd;
    i_param.rd && i_param.block == BLOCK_TRIP && i_param.id == TRIP_ID_STATUS
      |=> o_param_rdata == {15'h0000, $past(o_trip_status)};
  endproperty
  a_trip_rd: assert property (p_trip_rd) else $error("trip status read wrong");
  property p_trip_hold; quiet [*2] |=> $stable(o_trip_status); endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip moved without sample");
endmodule : rsatp_relay_trip_chk

bind rsatp_relay_trip rsatp_relay_trip_chk i_chk (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_param(i_param),
  .i_device_executing(i_device_executing),
  .i_idle_behaviour_selector(i_idle_behaviour_selector),
  .i_recoverable_fault(i_recoverable_fault), .i_unrecoverable_fault(i_unrecoverable_fault),
  .i_fault_is_critical(i_fault_is_critical), .i_diaphragm_sensor(i_diaphragm_sensor),
  .i_ambient_sensor(i_ambient_sensor), .o_param_rdata(o_param_rdata),
  .o_output_state(o_output_state), .o_relay(o_relay), .o_trip_status(o_trip_status),
  .o_critical_fault(o_critical_fault));

// ### testbench/rsatp_master_model.sv
`timescale 1ns/1ps
module rsatp_master_model
  import rsatp_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic [15:0] i_rdata,
  output rsatp_param_type  o_param
);
  initial o_param = '0;
  // one-cycle write pulse launched on the falling edge
  task automatic put(input logic b, input logic [7:0] pid, input logic [15:0] d);
    @(negedge i_mclk);
    o_param = '{wr: 1'b1, rd: 1'b0, block: b, id: pid, wdata: d};
    @(negedge i_mclk);
    o_param = '0;
  endtask : put
  // one-cycle read pulse, data taken one edge later
  task automatic get(input logic b, input logic [7:0] pid, output logic [15:0] d);
    @(negedge i_mclk);
    o_param = '{wr: 1'b0, rd: 1'b1, block: b, id: pid, wdata: 16'h0000};
    @(negedge i_mclk);
    o_param = '0;
    @(negedge i_mclk);
    d = i_rdata;
  endtask : get
endmodule : rsatp_master_model

// ### testbench/rsatp_relay_trip_tb.sv
`timescale 1ns/1ps
module rsatp_relay_trip_tb;
  import rsatp_pkg::*;
  logic             mclk = 1'b0;
  logic             resetn, execng, rflt, uflt, crit, relay, trip, critf;
  logic [7:0]       idle_sel;
  logic [15:0]      rdata;
  logic [2:0]       state;
  rsatp_param_type  param;
  rsatp_sample_type dia, amb;
  int               err_total = 0;
  int               n_tests = 0;
  int               cyc = 0;
  int               tv [5] = '{101, 100, 102, 103, 90};
  logic             te [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  always #2 mclk = ~mclk;
  rsatp_master_model i_rsatp_master_model (.i_mclk(mclk), .i_rdata(rdata), .o_param(param));
  rsatp_relay_trip i_rsatp_relay_trip (
    .i_mclk(mclk), .i_resetn(resetn), .i_param(param), .i_device_executing(execng),
    .i_idle_behaviour_selector(idle_sel), .i_recoverable_fault(rflt),
    .i_unrecoverable_fault(uflt), .i_fault_is_critical(crit), .i_diaphragm_sensor(dia),
    .i_ambient_sensor(amb), .o_param_rdata(rdata), .o_output_state(state),
    .o_relay(relay), .o_trip_status(trip), .o_critical_fault(critf));
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task automatic rchk(input logic b, input logic [7:0] p, input logic [15:0] e, input string nm);
    logic [15:0] d;
    i_rsatp_master_model.get(b, p, d);
    chk(nm, e, d);
  endtask : rchk
  task automatic cmd(input logic [7:0] c);
    i_rsatp_master_model.put(BLOCK_OUTPUT, OUT_ID_STATE_COMMAND, {8'h00, c});
    repeat (2) @(negedge mclk);
  endtask : cmd
  // one sensor sample, then room for the trip update
  task automatic smp(input logic amb_sel, input logic [15:0] v);
    @(negedge mclk);
    if (amb_sel) amb = '{valid: 1'b1, value: v};
    else dia = '{valid: 1'b1, value: v};
    @(negedge mclk);
    amb.valid = 1'b0;
    dia.valid = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : smp
  // hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      close_out;
    end
  end
  initial
  begin
    {resetn, rflt, uflt, crit, idle_sel} = '0;
    execng = 1'b1;
    dia = '0;
    amb = '0;
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    chk("state", 16'h0000, {13'h0000, state});
    rchk(BLOCK_OUTPUT, OUT_ID_STATE_COMMAND, {8'h00, RST_COMMAND}, "cmd");
    $display("test reset done");
    i_rsatp_master_model.put(BLOCK_OUTPUT, OUT_ID_REQUESTED, 16'h0001);
    for (int c = 1; c <= 6; c++)
    begin
      cmd(8'(c));
      chk("state", 16'(c - 1), {13'h0000, state});
    end
    cmd(CMD_READY);
    chk("relay", 16'h0001, {15'h0000, relay});
    cmd(CMD_IDLE);
    chk("relay", 16'h0000, {15'h0000, relay});
    cmd(CMD_READY);
    idle_sel = 8'h01;
    cmd(CMD_IDLE);
    chk("relay", 16'h0001, {15'h0000, relay});
    idle_sel = 8'h00;
    cmd(CMD_RUN);
    i_rsatp_master_model.put(BLOCK_OUTPUT, OUT_ID_REQUESTED, 16'h0002);
    repeat (2) @(negedge mclk);
    chk("relay", 16'h0000, {15'h0000, relay});
    cmd(8'h07);
    chk("state", {13'h0000, ST_RUN}, {13'h0000, state});
    rchk(BLOCK_OUTPUT, OUT_ID_STATE_COMMAND, 16'h0007, "cmd");
    execng = 1'b0;
    cmd(CMD_AVAILABLE);
    chk("state", {13'h0000, ST_RUN}, {13'h0000, state});
    execng = 1'b1;
    rflt = 1'b1;
    @(negedge mclk);
    rflt = 1'b0;
    @(negedge mclk);
    chk("state", {13'h0000, ST_RECOV_FAULT}, {13'h0000, state});
    {uflt, crit} = 2'h3;
    @(negedge mclk);
    {uflt, crit} = 2'h0;
    repeat (6) @(negedge mclk);
    chk("state", {13'h0000, ST_UNRECOV_FAULT}, {13'h0000, state});
    chk("crit", 16'h0001, {15'h0000, critf});
    rchk(BLOCK_OUTPUT, OUT_ID_STATUS, 16'h0001, "out_status");
    $display("test output block done");
    i_rsatp_master_model.put(BLOCK_TRIP, TRIP_ID_LOW_POINT, 16'h0064);
    i_rsatp_master_model.put(BLOCK_TRIP, TRIP_ID_HYSTERESIS, 16'h0002);
    i_rsatp_master_model.put(BLOCK_TRIP, TRIP_ID_LOW_ENABLE, 16'h0001);
    for (int k = 0; k < 5; k++)
    begin
      smp(1'b0, 16'(tv[k]));
      chk("trip", {15'h0000, te[k]}, {15'h0000, trip});
    end
    smp(1'b1, 16'h0000);
    chk("trip", 16'h0001, {15'h0000, trip});
    rchk(BLOCK_TRIP, TRIP_ID_STATUS, 16'h0001, "status");
    i_rsatp_master_model.put(BLOCK_TRIP, TRIP_ID_ATM_FRACTION, 16'h0032);
    rchk(BLOCK_TRIP, TRIP_ID_LOW_ENABLE, 16'h0000, "low_en");
    smp(1'b1, 16'h03e8);
    rchk(BLOCK_TRIP, TRIP_ID_HIGH_POINT, 16'h01f4, "high");
    rchk(BLOCK_TRIP, TRIP_ID_HIGH_ENABLE, 16'h0001, "high_en");
    i_rsatp_master_model.put(BLOCK_TRIP, TRIP_ID_LOW_ENABLE, 16'h0001);
    rchk(BLOCK_TRIP, TRIP_ID_ATM_FRACTION, 16'h0000, "fraction");
    rchk(BLOCK_TRIP, TRIP_ID_HIGH_ENABLE, 16'h0000, "high_en");
    i_rsatp_master_model.put(BLOCK_TRIP, TRIP_ID_ATM_FRACTION, 16'h0064);
    smp(1'b1, 16'h03e8);
    smp(1'b1, 16'h03e7);
    chk("trip", 16'h0001, {15'h0000, trip});
    smp(1'b1, 16'h03e4);
    chk("trip", 16'h0000, {15'h0000, trip});
    smp(1'b0, 16'h0000);
    chk("trip", 16'h0000, {15'h0000, trip});
    smp(1'b1, 16'h03e4);
    chk("trip", 16'h0001, {15'h0000, trip});
    $display("test trip point done");
    close_out;
  end
endmodule : rsatp_relay_trip_tb
